// ---- asr_receiver.sv ----
/*
 Asynchronous serial receiver with two-deep receive buffer, apb slave.
 Assumes rx_in synchronous to pclk; apb master per amba apb3.
*/
// Added by the designer: the address map and register access over APB.
`timescale 1ns/1ps
`include "asr_map.svh"

// Operation
// - receive complete flag tracks unread data
// - receiver disable flushes buffer, flag zero
// - interrupt requested while flag and enable set
// - data read removes oldest frame
// - error flags buffered with their frame
// - status writes leave error flags unchanged
// - error flags never raise interrupts
// - frame error shows head frame stop bit
// - only first stop bit checked
// - overrun when full, waiting, new start
// - overrun cleared on successful transfer
// - parity checked when enabled, type selectable
// - parity error zero when checking disabled
// - parity error valid until data read
// - disable is immediate, drops reception, releases pin
// - sample at sixteen or eight per bit
// - start bit voted on centre samples
// - resume edge search; resync every start
// - per-bit sample state equals sample number
// - bits decided by three-sample majority
// - zero stop bit sets frame error
// - enable hands pin to serial input
// - first stop bit moves frame to buffer
// - unused upper data bits read zero
// - ninth bit buffered with frame
module asr_receiver (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_in,
    output logic             rx_pin_owned,
    output logic             rx_complete_irq
);
    typedef struct packed {
        asr_pkg::asr_ctl_t        ctl;
        asr_pkg::asr_fmt_t        fmt;
        logic [15:0]              div;
        logic [15:0]              divcnt;
        logic                     tick;
        asr_pkg::asr_rx_t         rx;
        logic [4:0]               cnt;
        logic [2:0]               vote;
        logic                     prev;
        logic [3:0]               bitn;
        logic [8:0]               sh;
        logic                     pbit;
        asr_pkg::asr_entry_t      hold;
        logic                     hold_v;
        logic                     ovr;
        asr_pkg::asr_entry_t [1:0] buf_q;
        logic                     rdp;
        logic                     wrp;
        logic [1:0]               count;
        logic [31:0]              prdata;
        logic                     pready;
        logic                     pslverr;
        logic                     irq;
        logic                     own;
    } asr_state_t;

    asr_state_t s;
    asr_state_t next_s;

    function automatic asr_pkg::asr_reg_t dec(input logic [7:0] a);
        case (a)
            `ASR_OFF_DATA:   dec = asr_pkg::R_DATA;
            `ASR_OFF_STATUS: dec = asr_pkg::R_STATUS;
            `ASR_OFF_CTRL:   dec = asr_pkg::R_CTRL;
            `ASR_OFF_FMT:    dec = asr_pkg::R_FMT;
            `ASR_OFF_DIV:    dec = asr_pkg::R_DIV;
            default:         dec = asr_pkg::R_NONE;
        endcase
    endfunction : dec

    // 5..8 data bits, code 7 gives nine
    function automatic logic [3:0] nbits(input logic [2:0] cs);
        case (cs)
            3'h0:    nbits = 4'h5;
            3'h1:    nbits = 4'h6;
            3'h2:    nbits = 4'h7;
            3'h7:    nbits = 4'h9;
            default: nbits = 4'h8;
        endcase
    endfunction : nbits

    function automatic logic maj(input logic [2:0] v);
        maj = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction : maj

    asr_pkg::asr_entry_t head;
    logic [4:0]          spb;
    logic [4:0]          vlo;
    logic [4:0]          vhi;
    logic [4:0]          c;
    logic [2:0]          v;
    logic                b;
    logic                done;
    logic                push;
    logic                pop;
    logic                start_seen;
    logic                setup;
    logic                access;

    always_comb begin
        next_s     = s;
        head       = s.buf_q[s.rdp];
        spb        = s.ctl.double_speed_select ? `ASR_SPB_DS
                                               : `ASR_SPB_NORM;
        vlo        = s.ctl.double_speed_select ? `ASR_VOTE_DS
                                               : `ASR_VOTE_NORM;
        vhi        = vlo + 5'h02;
        c          = (s.cnt == spb) ? 5'h01 : s.cnt + 5'h01;
        v          = {s.vote[1:0], rx_in};
        b          = maj(v);
        done       = 1'b0;
        start_seen = 1'b0;
        setup      = psel && !penable;
        access     = psel && penable && s.pready;

        // sample tick from the divisor
        next_s.tick = (s.divcnt == s.div);
        next_s.divcnt = next_s.tick ? 16'h0000 : s.divcnt + 16'h0001;

        if (s.tick) begin
            next_s.prev = rx_in;
            if (s.rx == asr_pkg::RX_IDLE) begin
                if (s.prev && !rx_in) begin
                    start_seen   = 1'b1;
                    next_s.rx    = asr_pkg::RX_START;
                    next_s.cnt   = 5'h01;
                    next_s.sh    = 9'h000;
                    next_s.bitn  = 4'h0;
                end
            end else begin
                next_s.cnt = c;
                if (c >= vlo && c <= vhi) begin
                    next_s.vote = v;
                end
                case (s.rx)
                    asr_pkg::RX_START: begin
                        if (c == vhi && b) begin
                            next_s.rx = asr_pkg::RX_IDLE;
                        end else if (c == 5'h01) begin
                            next_s.rx = asr_pkg::RX_DATA;
                        end
                    end
                    asr_pkg::RX_DATA: begin
                        if (c == vhi) begin
                            next_s.sh[s.bitn] = b;
                            next_s.bitn = s.bitn + 4'h1;
                        end else if (c == 5'h01 &&
                                     s.bitn == nbits(
                                     s.fmt.character_size_field)) begin
                            next_s.rx = s.fmt.parity_enable
                                      ? asr_pkg::RX_PAR
                                      : asr_pkg::RX_STOP;
                        end
                    end
                    asr_pkg::RX_PAR: begin
                        if (c == vhi) begin
                            next_s.pbit = b;
                        end else if (c == 5'h01) begin
                            next_s.rx = asr_pkg::RX_STOP;
                        end
                    end
                    asr_pkg::RX_STOP: begin
                        if (c == vhi) begin
                            done      = 1'b1;
                            next_s.rx = asr_pkg::RX_IDLE;
                        end
                    end
                    default: next_s.rx = asr_pkg::RX_IDLE;
                endcase
            end
        end

        // full buffer, frame waiting, new start: overrun
        if (start_seen && s.hold_v && s.count == 2'h2) begin
            next_s.ovr = 1'b1;
        end

        pop  = access && !pwrite && dec(paddr) == asr_pkg::R_DATA &&
               s.count != 2'h0;
        push = s.hold_v && s.count != 2'h2;
        if (push) begin
            next_s.buf_q[s.wrp] = s.hold;
            next_s.buf_q[s.wrp].data_overrun_flag = s.ovr;
            next_s.ovr    = 1'b0;
            next_s.hold_v = 1'b0;
            next_s.wrp    = ~s.wrp;
        end
        if (pop) begin
            next_s.rdp = ~s.rdp;
        end
        next_s.count = s.count + {1'b0, push} - {1'b0, pop};

        if (done) begin
            next_s.hold.data = s.sh;
            next_s.hold.frame_error_flag = !b;
            next_s.hold.data_overrun_flag = 1'b0;
            next_s.hold.parity_error_flag = s.fmt.parity_enable &
                (s.pbit ^ (^s.sh) ^ s.fmt.parity_type_select);
            next_s.hold_v = 1'b1;
        end

        // apb: answer one cycle after setup
        next_s.pready  = setup;
        next_s.pslverr = setup && dec(paddr) == asr_pkg::R_NONE;
        if (setup) begin
            next_s.prdata = 32'h0000_0000;
            case (dec(paddr))
                asr_pkg::R_DATA: begin
                    next_s.prdata[7:0] = head.data[7:0];
                end
                asr_pkg::R_STATUS: begin
                    if (s.count != 2'h0) begin
                        next_s.prdata[`ASR_ST_RXC] = 1'b1;
                        next_s.prdata[`ASR_ST_FE] =
                            head.frame_error_flag;
                        next_s.prdata[`ASR_ST_DOR] =
                            head.data_overrun_flag;
                        next_s.prdata[`ASR_ST_PE] =
                            head.parity_error_flag;
                    end
                end
                asr_pkg::R_CTRL: begin
                    next_s.prdata[2:0] = s.ctl;
                    next_s.prdata[`ASR_CT_B8] =
                        (s.count != 2'h0) && head.data[8];
                end
                asr_pkg::R_FMT: begin
                    next_s.prdata[5:0] = s.fmt;
                end
                asr_pkg::R_DIV: begin
                    next_s.prdata[15:0] = s.div;
                end
                default: next_s.prdata = 32'h0000_0000;
            endcase
        end
        // status and data writes change nothing here
        if (access && pwrite) begin
            case (dec(paddr))
                asr_pkg::R_CTRL: next_s.ctl = pwdata[2:0];
                asr_pkg::R_FMT:  next_s.fmt = pwdata[5:0];
                asr_pkg::R_DIV:  next_s.div = pwdata[15:0];
                default:         next_s.div = s.div;
            endcase
        end

        // disabled: drop reception, flush buffer at once
        if (!s.ctl.receiver_enable) begin
            next_s.rx     = asr_pkg::RX_IDLE;
            next_s.count  = 2'h0;
            next_s.hold_v = 1'b0;
            next_s.ovr    = 1'b0;
            next_s.prev   = 1'b1;
            // realign pointers so the next push becomes the head
            next_s.rdp    = 1'b0;
            next_s.wrp    = 1'b0;
        end
        next_s.own = next_s.ctl.receiver_enable;
        next_s.irq = next_s.ctl.receive_complete_irq_enable &&
                     next_s.count != 2'h0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s        <= '0;
            s.ctl    <= `ASR_CTRL_RST;
            s.fmt    <= `ASR_FMT_RST;
            s.div    <= `ASR_DIV_RST;
            s.prev   <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign prdata          = s.prdata;
    assign pready          = s.pready;
    assign pslverr         = s.pslverr;
    assign rx_pin_owned    = s.own;
    assign rx_complete_irq = s.irq;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_data_read_full;
        psel && penable && s.pready && !pwrite &&
        paddr == `ASR_OFF_DATA && s.count == 2'h2;
    endsequence
    sequence s_stop_vote;
        s.tick && s.rx == asr_pkg::RX_STOP && c == vhi;
    endsequence

    property p_irq_follows;
        s.ctl.receive_complete_irq_enable && s.count != 2'h0
            |-> rx_complete_irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("irq missing while data waits");

    property p_irq_cause;
        rx_complete_irq |-> s.count != 2'h0;
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("irq without buffered data");

    property p_flush;
        !s.ctl.receiver_enable |=> s.count == 2'h0 &&
            rx_pin_owned == s.ctl.receiver_enable;
    endproperty
    a_flush: assert property (p_flush)
        else $error("buffer not flushed on disable");

    property p_pop;
        s_data_read_full ##0 !push |=> s.count == 2'h1;
    endproperty
    a_pop: assert property (p_pop)
        else $error("data read did not remove a frame");

    property p_overrun;
        start_seen && s.hold_v && s.count == 2'h2 &&
        s.ctl.receiver_enable && !pop |=> s.ovr;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not flagged");

    property p_ovr_clear;
        push && s.ctl.receiver_enable && !start_seen |=> !s.ovr;
    endproperty
    a_ovr_clear: assert property (p_ovr_clear)
        else $error("overrun not cleared on transfer");

    property p_stop_fe;
        s_stop_vote ##0 s.ctl.receiver_enable
            |=> s.hold_v && s.hold.frame_error_flag == !$past(b)
                && s.rx == asr_pkg::RX_IDLE;
    endproperty
    a_stop_fe: assert property (p_stop_fe)
        else $error("stop bit result wrong");

    property p_pe_off;
        done && !s.fmt.parity_enable |=> !s.hold.parity_error_flag;
    endproperty
    a_pe_off: assert property (p_pe_off)
        else $error("parity error with checking off");

    property p_cnt_range;
        s.rx != asr_pkg::RX_IDLE |-> s.cnt >= 5'h01 && s.cnt <= spb;
    endproperty
    a_cnt_range: assert property (p_cnt_range)
        else $error("sample state out of range");

    property p_reject;
        s.tick && s.rx == asr_pkg::RX_START && c == vhi && b
            && s.ctl.receiver_enable |=> s.rx == asr_pkg::RX_IDLE;
    endproperty
    a_reject: assert property (p_reject)
        else $error("noisy start bit accepted");

    property p_answer;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_answer: assert property (p_answer)
        else $error("apb answer timing wrong");
endmodule : asr_receiver

// ---- asr_map.svh ----
/*
 Register offsets, bit positions and reset values of the serial receiver.
 Assumes inclusion by bare name from the receiver module.
*/
`ifndef ASR_MAP_SVH
`define ASR_MAP_SVH
// byte offsets on the apb bus
`define ASR_OFF_DATA   8'h00
`define ASR_OFF_STATUS 8'h04
`define ASR_OFF_CTRL   8'h08
`define ASR_OFF_FMT    8'h0c
`define ASR_OFF_DIV    8'h10
// status bits
`define ASR_ST_PE      0
`define ASR_ST_DOR     1
`define ASR_ST_FE      2
`define ASR_ST_RXC     3
// control bits
`define ASR_CT_EN      0
`define ASR_CT_IE      1
`define ASR_CT_DS      2
`define ASR_CT_B8      3
// frame format bits
`define ASR_FM_PEN     0
`define ASR_FM_PTYPE   1
`define ASR_FM_STOP2   2
`define ASR_FM_CS_LO   3
`define ASR_FM_CS_HI   5
// reset values
`define ASR_CTRL_RST   3'h0
`define ASR_FMT_RST    6'h18
`define ASR_DIV_RST    16'h0000
// sample timing: samples per bit and first voting sample
`define ASR_SPB_NORM   5'h10
`define ASR_SPB_DS     5'h08
`define ASR_VOTE_NORM  5'h08
`define ASR_VOTE_DS    5'h04
`endif

// ---- asr_pkg.sv ----
/*
 Types of the serial receiver: register groups, buffer entry, state.
 Assumes nothing of its surroundings.
*/
package asr_pkg;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
        asr_rx_t;
    typedef enum logic [2:0] {R_DATA, R_STATUS, R_CTRL, R_FMT, R_DIV, R_NONE}
        asr_reg_t;
    typedef struct packed {
        logic       double_speed_select;
        logic       receive_complete_irq_enable;
        logic       receiver_enable;
    } asr_ctl_t;
    typedef struct packed {
        logic [2:0] character_size_field;
        logic       stop_bit_count_select;
        logic       parity_type_select;
        logic       parity_enable;
    } asr_fmt_t;
    typedef struct packed {
        logic [8:0] data;
        logic       frame_error_flag;
        logic       data_overrun_flag;
        logic       parity_error_flag;
    } asr_entry_t;
endpackage : asr_pkg

// ---- asr_tx_model.sv ----
/*
 Behavioural remote transmitter driving the serial receive line.
 Assumes the bench raises go for one cycle while busy is low.
*/
`timescale 1ns/1ps
module asr_tx_model (
    input  wire logic        pclk,
    input  wire logic        go,
    input  wire logic [11:0] bits,
    input  wire logic [3:0]  nbits,
    input  wire logic [7:0]  bit_cycles,
    output logic             line,
    output logic             busy
);
    initial begin
        line = 1'b1;
        busy = 1'b0;
    end
    // lsb first, each bit held a whole bit time, idle high between frames
    always @(posedge pclk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            for (int i = 0; i < nbits; i++) begin
                line <= bits[i];
                repeat (bit_cycles) @(posedge pclk);
            end
            line <= 1'b1;
            busy <= 1'b0;
        end
    end
endmodule : asr_tx_model

// ---- async_serial_receiver_test.sv ----
/*
 Self-checking bench of the serial receiver: apb master, line model.
 Assumes an apb slave answering within 16 cycles of enable and the baud divisor left at zero.
*/
`timescale 1ns/1ps
`include "asr_map.svh"
module async_serial_receiver_test;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rx_line;
    logic        rx_pin_owned;
    logic        rx_complete_irq;
    logic        go;
    logic [11:0] tx_bits;
    logic [3:0]  tx_n;
    logic [7:0]  tx_cyc;
    logic        tx_busy;
    int          bt;
    int          errors;
    int          checked;
    asr_receiver dut (
        .pclk            (pclk),
        .presetn         (presetn),
        .psel            (psel),
        .penable         (penable),
        .pwrite          (pwrite),
        .paddr           (paddr),
        .pwdata          (pwdata),
        .prdata          (prdata),
        .pready          (pready),
        .pslverr         (pslverr),
        .rx_in           (rx_line),
        .rx_pin_owned    (rx_pin_owned),
        .rx_complete_irq (rx_complete_irq)
    );
    asr_tx_model u_tx (
        .pclk       (pclk),
        .go         (go),
        .bits       (tx_bits),
        .nbits      (tx_n),
        .bit_cycles (tx_cyc),
        .line       (rx_line),
        .busy       (tx_busy)
    );
    always #2 pclk = ~pclk;
    task automatic test_done;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            errors++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, exp);
    endtask : rd_chk
    task automatic st(input logic [3:0] e);
        rd_chk(`ASR_OFF_STATUS, {28'h0, e});
    endtask : st
    task automatic dt(input logic [7:0] e);
        rd_chk(`ASR_OFF_DATA, {24'h0, e});
    endtask : dt
    task automatic pins(input logic [1:0] e);
        repeat (2) @(negedge pclk);
        chk({30'h0, rx_pin_owned, rx_complete_irq}, {30'h0, e});
    endtask : pins
    task automatic launch(input logic [11:0] v, input int n);
        @(posedge pclk);
        tx_bits <= v;
        tx_n    <= 4'(n);
        tx_cyc  <= 8'(bt);
        go      <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
    endtask : launch
    task automatic idle;
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (tx_busy !== 1'b0 && n < 400);
        if (tx_busy !== 1'b0) begin
            errors++;
            test_done();
        end
    endtask : idle
    task automatic send(input logic [8:0] d, input int nd, input logic pen,
                        input logic pb, input logic stp);
        logic [11:0] v;
        int          k;
        v = 12'hfff;
        v[0] = 1'b0;
        for (k = 0; k < nd; k++) v[k + 1] = d[k];
        k = nd + 1;
        if (pen) begin
            v[k] = pb;
            k++;
        end
        v[k] = stp;
        launch(v, k + 1);
        idle();
    endtask : send
    task automatic s_regs;
        logic [31:0] r;
        logic        e;
        rd_chk(`ASR_OFF_CTRL, 32'h0);
        rd_chk(`ASR_OFF_FMT, 32'h18);
        rd_chk(`ASR_OFF_DIV, 32'h0);
        st(4'h0);
        apb(1'b0, 8'h14, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        pins(2'b00);
    endtask : s_regs
    task automatic s_basic;
        wr(`ASR_OFF_CTRL, 32'h1);
        pins(2'b10);
        send(9'h0a5, 8, 1'b0, 1'b0, 1'b1);
        st(4'h8);
        pins(2'b10);
        wr(`ASR_OFF_CTRL, 32'h3);
        pins(2'b11);
        dt(8'ha5);
        st(4'h0);
        pins(2'b10);
    endtask : s_basic
    task automatic s_errors;
        wr(`ASR_OFF_CTRL, 32'h1);
        send(9'h03c, 8, 1'b0, 1'b0, 1'b0);
        pins(2'b10);
        st(4'hc);
        wr(`ASR_OFF_STATUS, 32'h0);
        st(4'hc);
        dt(8'h3c);
        wr(`ASR_OFF_FMT, 32'h1c);
        send(9'h081, 8, 1'b0, 1'b0, 1'b1);
        st(4'h8);
        dt(8'h81);
    endtask : s_errors
    task automatic s_parity;
        for (int pt = 0; pt < 2; pt++) begin
            for (int pb = 0; pb < 2; pb++) begin
                wr(`ASR_OFF_FMT, 32'h19 | 32'(pt << 1));
                send(9'h003, 8, 1'b1, 1'(pb), 1'b1);
                st(4'h8 | 4'(pb != pt));
                dt(8'h03);
            end
        end
        wr(`ASR_OFF_FMT, 32'h19);
        send(9'h007, 8, 1'b1, 1'b0, 1'b1);
        send(9'h006, 8, 1'b1, 1'b0, 1'b1);
        st(4'h9);
        dt(8'h07);
        st(4'h8);
        dt(8'h06);
        wr(`ASR_OFF_FMT, 32'h18);
    endtask : s_parity
    task automatic s_noise;
        bt = 5;
        launch(12'h000, 1);
        idle();
        bt = 16;
        repeat (20) @(posedge pclk);
        st(4'h0);
        send(9'h0da, 8, 1'b0, 1'b0, 1'b1);
        dt(8'hda);
    endtask : s_noise
    task automatic s_sizes;
        wr(`ASR_OFF_CTRL, 32'h5);
        wr(`ASR_OFF_FMT, 32'h10);
        bt = 8;
        send(9'h0d5, 7, 1'b0, 1'b0, 1'b1);
        dt(8'h55);
        wr(`ASR_OFF_CTRL, 32'h1);
        wr(`ASR_OFF_FMT, 32'h38);
        bt = 16;
        send(9'h1a5, 9, 1'b0, 1'b0, 1'b1);
        rd_chk(`ASR_OFF_CTRL, 32'h9);
        dt(8'ha5);
        wr(`ASR_OFF_FMT, 32'h0);
        send(9'h0f7, 5, 1'b0, 1'b0, 1'b1);
        dt(8'h17);
        wr(`ASR_OFF_FMT, 32'h18);
    endtask : s_sizes
    task automatic s_overrun;
        send(9'h011, 8, 1'b0, 1'b0, 1'b1);
        send(9'h022, 8, 1'b0, 1'b0, 1'b1);
        send(9'h033, 8, 1'b0, 1'b0, 1'b1);
        send(9'h044, 8, 1'b0, 1'b0, 1'b1);
        st(4'h8);
        dt(8'h11);
        st(4'h8);
        dt(8'h22);
        st(4'ha);
        dt(8'h44);
        send(9'h055, 8, 1'b0, 1'b0, 1'b1);
        st(4'h8);
        wr(`ASR_OFF_CTRL, 32'h0);
        pins(2'b00);
        st(4'h0);
        wr(`ASR_OFF_CTRL, 32'h1);
        launch(12'h3e0, 10);
        repeat (40) @(posedge pclk);
        wr(`ASR_OFF_CTRL, 32'h0);
        idle();
        wr(`ASR_OFF_CTRL, 32'h1);
        repeat (200) @(posedge pclk);
        st(4'h0);
        send(9'h066, 8, 1'b0, 1'b0, 1'b1);
        dt(8'h66);
    endtask : s_overrun
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        go = 1'b0;
        tx_bits = 12'hfff;
        tx_n = 4'h0;
        tx_cyc = 8'h10;
        bt = 16;
        errors = 0;
        checked = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        s_regs();
        s_basic();
        s_errors();
        s_parity();
        s_noise();
        s_sizes();
        s_overrun();
        test_done();
    end
endmodule : async_serial_receiver_test
